// File: rtl/bsm_pkg.sv
// bsm_pkg: constants, carriers and state codes for the buffer sync manager
// assumes one clock domain, an apb register port and one word per register
package bsm_pkg;
  localparam int          NUM_CH_DEF    = 16;
  localparam logic [4:0]  CH_REGION     = 5'h10;  // index bits 11:7 of 0x800..0x87f
  localparam int          HOST_VIEW_BIT = 14;     // paddr bit choosing the host view
  // register index inside a channel group, byte address is four times it
  localparam logic [2:0]  IDX_START     = 3'h0;
  localparam logic [2:0]  IDX_LEN       = 3'h2;
  localparam logic [2:0]  IDX_CTRL      = 3'h4;
  localparam logic [2:0]  IDX_STAT      = 3'h5;
  localparam logic [2:0]  IDX_ACT       = 3'h6;
  localparam logic [2:0]  IDX_HCTL      = 3'h7;
  // control byte fields
  localparam int          CTL_MODE_LSB  = 0;
  localparam int          CTL_DIR_LSB   = 2;
  localparam int          CTL_NET_EV    = 4;
  localparam int          CTL_HOST_EV   = 5;
  localparam int          CTL_WDOG      = 6;
  localparam logic [1:0]  MODE_BUF3     = 2'h0;
  localparam logic [1:0]  MODE_MBX      = 2'h2;
  localparam logic [1:0]  DIR_NET_RD    = 2'h0;
  localparam logic [1:0]  DIR_NET_WR    = 2'h1;
  // activate and host control fields
  localparam int          ACT_EN        = 0;
  localparam int          HCTL_DEACT    = 0;
  localparam int          HCTL_REP_ACK  = 1;
  localparam logic [7:0]  CTL_WMASK     = 8'h7f;
  localparam logic [7:0]  ACT_WMASK     = 8'hc3;
  localparam logic [1:0]  BUF_NONE      = 2'h3;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_WORD      = 16'h0000;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
  } bsm_acc_t;

  typedef struct packed {
    logic        valid;
    logic        grant;
    logic [15:0] phys;
  } bsm_rsp_t;

  typedef struct packed {
    logic [15:0] start;
    logic [15:0] len;
    logic [7:0]  ctrl;
    logic        enable;
    logic        deact;
  } bsm_cfg_t;

  typedef enum logic [1:0] {
    BSM_IDLE   = 2'h1,
    BSM_ACCESS = 2'h2
  } bsm_apb_st_t;
endpackage

// File: rtl/bsm_channel.sv
// bsm_channel: buffer handling and status for one sync channel
// assumes registered configuration and access strobes of one cycle each
`timescale 1ns/1ps
`default_nettype none
module bsm_channel
  import bsm_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     arst_n,
  input  wire bsm_cfg_t cfg,
  input  wire bsm_acc_t net_acc,
  input  wire bsm_acc_t host_acc,
  output logic [7:0]    status,
  output bsm_rsp_t      net_rsp,
  output bsm_rsp_t      host_rsp,
  output logic          net_event,
  output logic          host_event,
  output logic          wdog
);
  logic       net_wr, mbx, buf3, active, single;
  logic [16:0] end_a;
  logic [15:0] last_a, wphys, rphys;
  bsm_acc_t   wa, ra;
  logic       w_ok, r_ok, w_first, w_last, r_first, r_last;
  logic       wr_done_reg, rd_done_reg, full_reg, rd_open_reg, wr_open_reg;
  logic [1:0] last_reg, wbuf_reg, rbuf_reg, rbuf_next;

  function automatic logic hit(input bsm_acc_t a);
    hit = a.valid && a.addr >= cfg.start && {1'b0, a.addr} < end_a;
  endfunction
  // byte offset of a buffer inside the tripled area
  function automatic logic [15:0] boff(input logic [1:0] b);
    boff = (b == 2'h1) ? cfg.len : (b == 2'h2) ? {cfg.len[14:0], 1'b0} : 16'h0000;
  endfunction
  // first buffer that neither party holds
  function automatic logic [1:0] spare(input logic [1:0] x, input logic [1:0] y);
    spare = (x != 2'h0 && y != 2'h0) ? 2'h0 : (x != 2'h1 && y != 2'h1) ? 2'h1 : 2'h2;
  endfunction

  // ---------------------------------------------------------------
  // access qualification
  // ---------------------------------------------------------------
  assign net_wr = cfg.ctrl[CTL_DIR_LSB +: 2] == DIR_NET_WR;
  assign mbx    = cfg.ctrl[CTL_MODE_LSB +: 2] == MODE_MBX;
  assign buf3   = cfg.ctrl[CTL_MODE_LSB +: 2] == MODE_BUF3;
  assign end_a  = {1'b0, cfg.start} + {1'b0, cfg.len};
  assign last_a = end_a[15:0] - 16'h0001;
  // reserved mode or direction codes leave the channel idle
  assign active = cfg.enable && !cfg.deact && cfg.len > 16'h0001 && (mbx || buf3)
                  && !cfg.ctrl[CTL_DIR_LSB+1];
  assign single = cfg.enable && !cfg.deact && cfg.len == 16'h0001;
  assign wa      = net_wr ? net_acc : host_acc;
  assign ra      = net_wr ? host_acc : net_acc;
  // a full mailbox refuses the writer, an empty one the reader
  assign w_ok    = active && hit(wa) && wa.write && !(mbx && full_reg);
  assign r_ok    = active && hit(ra) && !ra.write && !(mbx && !full_reg);
  assign w_first = w_ok && wa.addr == cfg.start;
  assign w_last  = w_ok && wa.addr == last_a;
  assign r_first = r_ok && ra.addr == cfg.start;
  assign r_last  = r_ok && ra.addr == last_a;
  // reader opens on the newest complete buffer, never the one being filled
  assign rbuf_next = !r_first ? rbuf_reg
                   : (last_reg == BUF_NONE) ? spare(wbuf_reg, wbuf_reg) : last_reg;
  assign wphys = wa.addr + (buf3 ? boff(wbuf_reg) : 16'h0000);
  assign rphys = ra.addr + (buf3 ? boff(rbuf_next) : 16'h0000);

  // ---------------------------------------------------------------
  // status flags, set wins over clear in the same cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_done_reg <= 1'b0;
    end else if (!active) begin
      wr_done_reg <= 1'b0;
    end else if (w_last) begin
      wr_done_reg <= 1'b1;
    end else if (r_first) begin
      wr_done_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_done_reg <= 1'b0;
    end else if (!active) begin
      rd_done_reg <= 1'b0;
    end else if (r_last) begin
      rd_done_reg <= 1'b1;
    end else if (w_first) begin
      rd_done_reg <= 1'b0;
    end
  end

  // mailbox fill and open-buffer flags
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      full_reg    <= 1'b0;
      wr_open_reg <= 1'b0;
      rd_open_reg <= 1'b0;
    end else if (!active) begin
      full_reg    <= 1'b0;
      wr_open_reg <= 1'b0;
      rd_open_reg <= 1'b0;
    end else begin
      if (mbx && w_last) full_reg <= 1'b1;
      else if (mbx && r_last) full_reg <= 1'b0;
      if (w_first) wr_open_reg <= 1'b1;
      else if (w_last) wr_open_reg <= 1'b0;
      if (r_first) rd_open_reg <= 1'b1;
      else if (r_last) rd_open_reg <= 1'b0;
    end
  end

  // three-buffer rotation
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      last_reg <= BUF_NONE;
      wbuf_reg <= 2'h0;
      rbuf_reg <= 2'h0;
    end else if (!active) begin
      last_reg <= BUF_NONE;
      wbuf_reg <= 2'h0;
      rbuf_reg <= 2'h0;
    end else begin
      rbuf_reg <= rbuf_next;
      if (buf3 && w_last) begin
        last_reg <= wbuf_reg;
        wbuf_reg <= spare(wbuf_reg, (rd_open_reg || r_first) ? rbuf_next : wbuf_reg);
      end
    end
  end

  assign status = {wr_open_reg, rd_open_reg, buf3 ? last_reg : 2'h0,
                   mbx && full_reg, 1'b0, rd_done_reg, wr_done_reg};

  // ---------------------------------------------------------------
  // answers, events and watchdog, one cycle after the access
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      net_rsp    <= '0;
      host_rsp   <= '0;
      net_event  <= 1'b0;
      host_event <= 1'b0;
      wdog       <= 1'b0;
    end else begin
      net_rsp.valid  <= active && hit(net_acc);
      net_rsp.grant  <= net_wr ? w_ok : r_ok;
      net_rsp.phys   <= net_wr ? wphys : rphys;
      host_rsp.valid <= active && hit(host_acc);
      host_rsp.grant <= net_wr ? r_ok : w_ok;
      host_rsp.phys  <= net_wr ? rphys : wphys;
      net_event  <= cfg.ctrl[CTL_NET_EV] && (net_wr ? r_last : w_last);
      host_event <= cfg.ctrl[CTL_HOST_EV] && (net_wr ? w_last : r_last);
      wdog <= cfg.ctrl[CTL_WDOG] && (w_last || (single && wa.valid && wa.write
              && wa.addr == cfg.start));
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_fill_done;
    w_last && buf3;
  endsequence
  sequence s_open_write;
    w_first ##1 !w_last;
  endsequence

  a_short_len: assert property (cfg.len < 16'h0002 |=> !wr_open_reg && !rd_open_reg)
    else $error("short channel opened a buffer");
  a_single_wdog: assert property (single && cfg.ctrl[CTL_WDOG] && wa.valid && wa.write
    && wa.addr == cfg.start |=> wdog && !status[0])
    else $error("single-byte channel watchdog missing");
  a_net_event: assert property (net_event |-> $past(cfg.ctrl[CTL_NET_EV]))
    else $error("network event while disabled");
  a_host_event: assert property ($rose(host_event) |-> $past(cfg.ctrl[CTL_HOST_EV]))
    else $error("host event while disabled");
  a_write_done: assert property (w_last |=> status[0] ##1 (status[0] || $past(r_first)))
    else $error("write-done flag not held");
  a_read_clear: assert property (w_first && !r_last |=> !status[1])
    else $error("read-done not cleared by write");
  a_mbx_full: assert property (mbx && w_last && active |=> status[3])
    else $error("mailbox not full after write");
  a_last_buf: assert property (s_fill_done |=> status[5:4] == $past(wbuf_reg))
    else $error("last written buffer wrong");
  a_wr_open: assert property (s_open_write |-> status[7])
    else $error("write buffer not shown open");
  a_no_overrun: assert property (buf3 && rd_open_reg |-> wbuf_reg != rbuf_reg)
    else $error("writer shares the read buffer");
endmodule
`default_nettype wire

// File: rtl/bsm_top.sv
// bsm_top: apb register file and sixteen buffer sync channels
// assumes apb master on clock, access strobes from both sides in one cycle
`timescale 1ns/1ps
`default_nettype none
module bsm_top
  import bsm_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF
)(
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [15:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire bsm_acc_t          net_acc,
  input  wire bsm_acc_t          host_acc,
  input  wire logic              frame_end,
  output bsm_rsp_t               net_rsp,
  output bsm_rsp_t               host_rsp,
  output logic [NUM_CH-1:0]      net_event,
  output logic [NUM_CH-1:0]      host_event,
  output logic                   wdog_trigger
);
  bsm_apb_st_t                   st_reg;
  logic                          setup, fire, map_ok, host_view;
  logic [3:0]                    ch;
  logic [2:0]                    fld;
  logic [31:0]                   rd_word;
  logic [NUM_CH-1:0][15:0]       start_q;
  logic [NUM_CH-1:0][15:0]       len_q;
  logic [NUM_CH-1:0][7:0]        ctrl_q;
  logic [NUM_CH-1:0][7:0]        act_q;
  logic [NUM_CH-1:0][7:0]        stat_w;
  logic [NUM_CH-1:0]             deact_q;
  logic [NUM_CH-1:0]             pend_q;
  logic [NUM_CH-1:0]             rep_q;
  logic [NUM_CH-1:0]             wdog_w;
  bsm_rsp_t [NUM_CH-1:0]         net_w;
  bsm_rsp_t [NUM_CH-1:0]         host_w;
  bsm_acc_t                      net_d_reg, host_d_reg;

  // ---------------------------------------------------------------
  // apb decode: index = byte address / 4, channel group at 0x800
  // ---------------------------------------------------------------
  assign host_view = paddr[HOST_VIEW_BIT];
  assign ch        = paddr[8:5];
  assign fld       = paddr[4:2];
  assign map_ok = paddr[1:0] == 2'h0 && !paddr[15] && paddr[13:9] == CH_REGION
                  && {1'b0, ch} < 5'(NUM_CH)
                  && fld != 3'h1 && fld != 3'h3;
  assign setup  = psel && !penable && st_reg == BSM_IDLE;
  assign pready = st_reg == BSM_ACCESS;
  assign fire   = psel && penable && pready && !pslverr;

  // two-state slave, zero wait states
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= BSM_IDLE;
    end else begin
      case (st_reg)
        BSM_IDLE:   st_reg <= setup ? BSM_ACCESS : BSM_IDLE;
        BSM_ACCESS: st_reg <= BSM_IDLE;
        default:    st_reg <= BSM_IDLE;
      endcase
    end
  end

  // read word, both views see the same contents
  always_comb begin
    rd_word = 32'h0000_0000;
    case (fld)
      IDX_START: rd_word[15:0] = start_q[ch];
      IDX_LEN:   rd_word[15:0] = len_q[ch];
      IDX_CTRL:  rd_word[7:0]  = ctrl_q[ch];
      IDX_STAT:  rd_word[7:0]  = stat_w[ch];
      IDX_ACT:   rd_word[7:0]  = act_q[ch];
      IDX_HCTL:  rd_word[1:0]  = {rep_q[ch], deact_q[ch]};
      default:   rd_word = 32'h0000_0000;
    endcase
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= (map_ok && !pwrite) ? rd_word : 32'h0000_0000;
      pslverr <= !map_ok;
    end else if (pready) begin
      pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // per-channel registers and core
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic     nw, hw;
    bsm_cfg_t cfg;

    assign nw  = fire && pwrite && !host_view && ch == 4'(g);
    assign hw  = fire && pwrite && host_view && ch == 4'(g);
    assign cfg = '{start: start_q[g], len: len_q[g], ctrl: ctrl_q[g],
                   enable: act_q[g][ACT_EN], deact: deact_q[g]};

    // layout frozen while enabled so a running exchange cannot move
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        start_q[g] <= RST_WORD;
        len_q[g]   <= RST_WORD;
      end else if (nw && !act_q[g][ACT_EN]) begin
        if (fld == IDX_START) begin
          start_q[g] <= {pstrb[1] ? pwdata[15:8] : start_q[g][15:8],
                         pstrb[0] ? pwdata[7:0] : start_q[g][7:0]};
        end
        if (fld == IDX_LEN) begin
          len_q[g] <= {pstrb[1] ? pwdata[15:8] : len_q[g][15:8],
                       pstrb[0] ? pwdata[7:0] : len_q[g][7:0]};
        end
      end
    end

    // control: watchdog enable stays writable, the rest locks
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        ctrl_q[g] <= RST_BYTE;
      end else if (nw && fld == IDX_CTRL && pstrb[0]) begin
        ctrl_q[g] <= act_q[g][ACT_EN]
                   ? {1'b0, pwdata[CTL_WDOG], ctrl_q[g][5:0]}
                   : pwdata[7:0] & CTL_WMASK;
      end
    end

    // activate: network only, host writes are ignored
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        act_q[g] <= RST_BYTE;
      end else if (nw && fld == IDX_ACT && pstrb[0]) begin
        act_q[g] <= pwdata[7:0] & ACT_WMASK;
      end
    end

    // host deactivation waits for the running frame to end
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        deact_q[g] <= 1'b0;
        pend_q[g]  <= 1'b0;
        rep_q[g]   <= 1'b0;
      end else if (hw && fld == IDX_HCTL && pstrb[0]) begin
        rep_q[g]  <= pwdata[HCTL_REP_ACK];
        pend_q[g] <= pwdata[HCTL_DEACT];
        if (!pwdata[HCTL_DEACT]) begin
          deact_q[g] <= 1'b0;
        end
      end else if (pend_q[g] && frame_end) begin
        deact_q[g] <= 1'b1;
        pend_q[g]  <= 1'b0;
      end
    end

    bsm_channel u_ch (
      .clock      (clock),
      .arst_n     (arst_n),
      .cfg        (cfg),
      .net_acc    (net_acc),
      .host_acc   (host_acc),
      .status     (stat_w[g]),
      .net_rsp    (net_w[g]),
      .host_rsp   (host_w[g]),
      .net_event  (net_event[g]),
      .host_event (host_event[g]),
      .wdog       (wdog_w[g])
    );
  end

  assign wdog_trigger = |wdog_w;

  // ---------------------------------------------------------------
  // answer merge: lowest claiming channel wins, else plain access
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      net_d_reg  <= '0;
      host_d_reg <= '0;
    end else begin
      net_d_reg  <= net_acc;
      host_d_reg <= host_acc;
    end
  end

  // overlapping areas are a setup fault; priority keeps them defined
  always_comb begin
    net_rsp = '{valid: net_d_reg.valid, grant: net_d_reg.valid, phys: net_d_reg.addr};
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (net_w[i].valid) net_rsp = net_w[i];
    end
  end

  always_comb begin
    host_rsp = '{valid: host_d_reg.valid, grant: host_d_reg.valid, phys: host_d_reg.addr};
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (host_w[i].valid) host_rsp = host_w[i];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_map_error: assert property (@(posedge clock) disable iff (!arst_n)
    setup && !map_ok |=> pslverr && pready)
    else $error("unmapped access not refused");
  a_lock_layout: assert property (@(posedge clock) disable iff (!arst_n)
    fire && pwrite && !host_view && act_q[ch][ACT_EN] && fld == IDX_START
    |=> $stable(start_q))
    else $error("start address changed while enabled");
  a_deact_wait: assert property (@(posedge clock) disable iff (!arst_n)
    pend_q[0] && !frame_end && !(fire && host_view) |=> $stable(deact_q[0]))
    else $error("deactivation before frame end");
  a_apb_answer: assert property (@(posedge clock) disable iff (!arst_n)
    setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
endmodule
`default_nettype wire

// File: verification/bsm_far_model.sv
// bsm_far_model: network frame processor and local host, byte accessors
// assumes one access per cycle per side and an answer one cycle later
`timescale 1ns/1ps
`default_nettype none
module bsm_far_model
  import bsm_pkg::*;
(
  input  wire logic     clock,
  input  wire bsm_rsp_t net_rsp,
  input  wire bsm_rsp_t host_rsp,
  output var bsm_acc_t  net_acc,
  output var bsm_acc_t  host_acc
);
  int          granted = 0;
  int          refused = 0;
  logic [15:0] last_phys;

  // tally every answer, refusals apart from grants
  always_ff @(posedge clock) begin
    if (net_rsp.valid || host_rsp.valid) begin
      granted   <= granted + int'(net_rsp.grant) + int'(host_rsp.grant);
      refused   <= refused + int'(net_rsp.valid & !net_rsp.grant)
                   + int'(host_rsp.valid & !host_rsp.grant);
      last_phys <= net_rsp.valid ? net_rsp.phys : host_rsp.phys;
    end
  end

  // one byte a cycle; a released address is inverted so it never looks live
  task automatic burst(input logic host, input logic wr, input logic [15:0] a, input int n);
    bsm_acc_t acc;
    for (int i = 0; i < n; i++) begin
      acc = '{1'b1, wr, a + 16'(i)};
      @(posedge clock);
      if (host)
        host_acc <= acc;
      else
        net_acc <= acc;
    end
    @(posedge clock);
    net_acc  <= '{1'b0, 1'b0, ~net_acc.addr};
    host_acc <= '{1'b0, 1'b0, ~host_acc.addr};
    repeat (2) @(posedge clock);
  endtask

  initial begin
    net_acc  = '0;
    host_acc = '0;
  end
endmodule
`default_nettype wire

// File: verification/bsm_top_tb.sv
// bsm_top_tb: register and byte access tests of the buffer sync manager
// assumes an apb slave that answers in time and the far model on the byte ports
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module bsm_top_tb
  import bsm_pkg::*;
;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        frame_end = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  bsm_acc_t    net_acc;
  bsm_acc_t    host_acc;
  bsm_rsp_t    net_rsp;
  bsm_rsp_t    host_rsp;
  logic [15:0] net_event;
  logic [15:0] host_event;
  logic        wdog_trigger;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          tests_run = 0;
  int          host_ev = 0;
  int          net_ev0 = 0;
  int          net_ev1 = 0;
  int          wd = 0;

  always #12.5 clock = ~clock;

  bsm_top bsm_top_inst (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .net_acc, .host_acc, .frame_end, .net_rsp, .host_rsp,
    .net_event, .host_event, .wdog_trigger);
  bsm_far_model far_inst (.clock, .net_rsp, .host_rsp, .net_acc, .host_acc);

  // event pulses last one cycle, so they are tallied rather than polled
  always_ff @(posedge clock) begin
    host_ev <= host_ev + int'(host_event[0]);
    net_ev0 <= net_ev0 + int'(net_event[0]);
    net_ev1 <= net_ev1 + int'(net_event[1]);
    wd      <= wd + int'(wdog_trigger);
  end

  function automatic logic [15:0] ra(input int ch, input int f);
    return 16'((32'h800 + ch * 8 + f) * 4);
  endfunction

  // one transfer; pready, read data and error are taken at one rising edge,
  // and the request is only released there, so wait states cannot cut it
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd       = prdata;
    err      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input int ch, input logic [15:0] s, input logic [15:0] l, input logic [7:0] c);
    apb(1'b1, ra(ch, 0), {16'h0, s});
    apb(1'b1, ra(ch, 2), {16'h0, l});
    apb(1'b1, ra(ch, 4), {24'h0, c});
    apb(1'b1, ra(ch, 6), 32'h1);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // cut a hang short well past the expected run of about 130 cycles
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    apb(1'b0, ra(0, 5), 32'h0);
    `CHK("status reset", 8'h30, rd[7:0])
    apb(1'b0, ra(16, 0), 32'h0);
    `CHK("beyond last", 1'b1, err)
    apb(1'b0, ra(0, 1), 32'h0);
    `CHK("gap field", 1'b1, err)
    // mailbox, network writes, host reads, host events only
    cfg(0, 16'h1000, 16'h4, 8'h26);
    apb(1'b1, ra(0, 0), 32'h5555);
    apb(1'b1, ra(0, 0) | 16'h4000, 32'h6666);
    apb(1'b0, ra(0, 0), 32'h0);
    `CHK("start locked", 16'h1000, rd[15:0])
    `CHK("mapped no error", 1'b0, err)
    far_inst.burst(1'b0, 1'b1, 16'h1000, 1);
    apb(1'b0, ra(0, 5), 32'h0);
    `CHK("write open", 1'b1, rd[7])
    far_inst.burst(1'b0, 1'b1, 16'h1001, 3);
    apb(1'b0, ra(0, 5), 32'h0);
    `CHK("mailbox full", 5'h09, {rd[7], rd[3:0]})
    far_inst.burst(1'b0, 1'b1, 16'h1000, 1);
    `CHK("full refused", 1, far_inst.refused)
    far_inst.burst(1'b1, 1'b0, 16'h1000, 1);
    apb(1'b0, ra(0, 5), 32'h0);
    `CHK("read open", 3'h4, {rd[6], rd[1:0]})
    far_inst.burst(1'b1, 1'b0, 16'h1001, 3);
    apb(1'b0, ra(0, 5), 32'h0);
    `CHK("mailbox empty", 4'h2, {rd[6], rd[3], rd[1:0]})
    `CHK("host events", 1, host_ev)
    `CHK("net events off", 0, net_ev0)
    // three buffers, host writes twice, network reads the newest
    cfg(1, 16'h2000, 16'h2, 8'h10);
    far_inst.burst(1'b1, 1'b1, 16'h2000, 2);
    apb(1'b0, ra(1, 5), 32'h0);
    `CHK("last buffer", 2'h0, rd[5:4])
    far_inst.burst(1'b1, 1'b1, 16'h2000, 2);
    `CHK("second buffer", 16'h2003, far_inst.last_phys)
    apb(1'b0, ra(1, 5), 32'h0);
    `CHK("last buffer", 2'h1, rd[5:4])
    far_inst.burst(1'b0, 1'b0, 16'h2000, 1);
    `CHK("newest read", 16'h2002, far_inst.last_phys)
    `CHK("net events", 2, net_ev1)
    // a length of one only triggers the watchdog
    cfg(2, 16'h3000, 16'h1, 8'h40);
    far_inst.burst(1'b1, 1'b1, 16'h3000, 1);
    `CHK("watchdog", 1, wd)
    `CHK("grants", 14, far_inst.granted)
    // host deactivation waits for the frame end
    apb(1'b1, ra(0, 7) | 16'h4000, 32'h1);
    apb(1'b0, ra(0, 7), 32'h0);
    `CHK("deact pending", 1'b0, rd[0])
    @(posedge clock);
    frame_end <= 1'b1;
    @(posedge clock);
    frame_end <= 1'b0;
    apb(1'b0, ra(0, 7), 32'h0);
    `CHK("deact applied", 1'b1, rd[0])
    final_report();
  end
endmodule
`default_nettype wire
